// file: logic/rss_pkg.sv
package rss_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] OFS_DELAY_LOW      = 8'h20;
  localparam logic [7:0] OFS_DELAY_HIGH     = 8'h21;
  localparam logic [7:0] OFS_ASSIGN_A       = 8'h22;
  localparam logic [7:0] OFS_ASSIGN_B       = 8'h23;

  localparam logic [7:0] RST_DELAY_LOW      = 8'h00;
  localparam logic [7:0] RST_DELAY_HIGH     = 8'h00;
  localparam logic [7:0] RST_ASSIGN_A       = 8'h86;
  localparam logic [7:0] RST_ASSIGN_B       = 8'h84;

  localparam int         STRETCH_BIT        = 7;
  localparam int         SLOT9_BIT          = 0;
  localparam int         FIELD_HI_LSB       = 4;
  localparam int         FIELD_LO_LSB       = 0;
  localparam int         FIELD_W            = 4;
  localparam int         NUM_RAILS          = 4;

  // ****************************************************************
  // Strobe numbering
  // ****************************************************************
  localparam logic [3:0] STROBE_FIRST       = 4'h1;
  localparam logic [3:0] STROBE_SEALED_FIRST = 4'h3;
  localparam logic [3:0] STROBE_LAST        = 4'hA;
  localparam logic [3:0] CODE_MIN           = 4'h3;
  localparam logic [3:0] CODE_MAX           = 4'hA;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_HZ         = 250_000_000;
  localparam int WAIT_SHORT_MS  = 2;
  localparam int WAIT_LONG_MS   = 5;
  localparam int WAIT_SHORT_CYC = WAIT_SHORT_MS * (CLK_HZ / 1000);
  localparam int WAIT_LONG_CYC  = WAIT_LONG_MS * (CLK_HZ / 1000);
  localparam int STRETCH_MULT   = 10;
  localparam int TIMER_W        = 24;

  // ****************************************************************
  // Sequencer states
  // ****************************************************************
  typedef enum logic [1:0] {
    RSS_IDLE   = 2'h0,
    RSS_STROBE = 2'h1,
    RSS_WAIT   = 2'h3
  } rss_state_t;

endpackage : rss_pkg

// file: logic/rss_timer_if.sv
`timescale 1ns/1ps
// ****************************************************************
// Wait timer handshake
// ****************************************************************
interface rss_timer_if #(
  parameter int W = rss_pkg::TIMER_W
);
  logic         load;
  logic [W-1:0] cycles;
  logic         done;

  modport ctl (output load, output cycles, input done);
  modport tmr (input load, input cycles, output done);
endinterface : rss_timer_if

// file: logic/rss_rst_sync.sv
`timescale 1ns/1ps
// ****************************************************************
// Reset release synchroniser
// ****************************************************************
module rss_rst_sync (
  input  wire logic clk,     // System clock
  input  wire logic arst_n,  // Asynchronous reset in
  output logic      rst_n    // Reset, released on clock
);
  logic stage1;

  // Assert at once, release two edges later to avoid metastable exit
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      stage1 <= 1'b1;
      rst_n  <= stage1;
    end
  end
endmodule : rss_rst_sync

// file: logic/rss_wait_timer.sv
`timescale 1ns/1ps
// ****************************************************************
// Inter-strobe wait counter
// ****************************************************************
module rss_wait_timer #(
  parameter int W = rss_pkg::TIMER_W
) (
  input  wire logic  clk,    // System clock
  input  wire logic  rst_n,  // Synchronous-release reset
  rss_timer_if.tmr   tif     // Load and done handshake
);
  logic [W-1:0] count;
  logic         running;

  // Done fires exactly cycles - 1 edges after the load edge
  assign tif.done = running && (count == W'(1));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count   <= '0;
      running <= 1'b0;
    end else if (tif.load) begin
      count   <= tif.cycles;
      running <= 1'b1;
    end else if (running) begin
      count   <= count - W'(1);
      running <= (count != W'(1));
    end
  end
endmodule : rss_wait_timer

// file: logic/rss_sequencer.sv
`timescale 1ns/1ps
// ****************************************************************
// Rail strobe sequencer with delay and assignment registers
// ****************************************************************
module rss_sequencer #(
  parameter int SHORT_CYCLES = rss_pkg::WAIT_SHORT_CYC,
  parameter int LONG_CYCLES  = rss_pkg::WAIT_LONG_CYC,
  parameter int STRETCH      = rss_pkg::STRETCH_MULT,
  parameter int TW           = rss_pkg::TIMER_W
) (
  input  wire logic       clk,                 // 250 MHz clock
  input  wire logic       arst_n,              // Async reset, low
  input  wire logic [7:0] reg_addr,            // Register subaddress
  input  wire logic       reg_wr_en,           // Write strobe
  input  wire logic [7:0] reg_wdata,           // Write data
  input  wire logic       reg_rd_en,           // Read strobe
  output logic      [7:0] reg_rdata,           // Read data, registered
  input  wire logic       power_up_req,        // Start power-up
  input  wire logic       power_down_req,      // Start power-down
  input  wire logic       freshness_seal_flag, // Seal broken when high
  output logic      [3:0] rail_en,             // Per-rail enables
  output logic      [3:0] strobe_num,          // Current strobe
  output logic            strobe_pulse,        // Strobe executed
  output logic            seq_busy,            // Sequence running
  output logic            seq_dir_down         // Running power-down
);

  // ****************************************************************
  // Functions
  // ****************************************************************
  function automatic logic field_hits(input logic [3:0] field,
                                      input logic [3:0] strobe);
    logic in_range;
    in_range = (field >= rss_pkg::CODE_MIN) &&
               (field <= rss_pkg::CODE_MAX);
    return in_range && (field == strobe);
  endfunction : field_hits

  function automatic logic [TW-1:0] wait_len(input logic long_sel,
                                             input logic stretch);
    int base;
    base = long_sel ? LONG_CYCLES : SHORT_CYCLES;
    if (stretch) begin
      base = base * STRETCH;
    end
    return TW'(base);
  endfunction : wait_len

  // ****************************************************************
  // Reset and timer
  // ****************************************************************
  logic rst_n;

  rss_rst_sync u_rst (
    .clk    (clk),
    .arst_n (arst_n),
    .rst_n  (rst_n)
  );

  rss_timer_if #(.W(TW)) tif ();

  rss_wait_timer #(.W(TW)) u_timer (
    .clk   (clk),
    .rst_n (rst_n),
    .tif   (tif)
  );

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [7:0] delay_select_low;
  logic       wait_slot_9;
  logic       power_down_stretch_factor;
  logic [7:0] buck_pair_a_strobe_assign;
  logic [7:0] buck_pair_b_strobe_assign;

  wire logic wr_low  = reg_wr_en && (reg_addr == rss_pkg::OFS_DELAY_LOW);
  wire logic wr_high = reg_wr_en && (reg_addr == rss_pkg::OFS_DELAY_HIGH);
  wire logic wr_a    = reg_wr_en && (reg_addr == rss_pkg::OFS_ASSIGN_A);
  wire logic wr_b    = reg_wr_en && (reg_addr == rss_pkg::OFS_ASSIGN_B);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      delay_select_low <= rss_pkg::RST_DELAY_LOW;
    end else if (wr_low) begin
      delay_select_low <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_slot_9 <= rss_pkg::RST_DELAY_HIGH[rss_pkg::SLOT9_BIT];
      power_down_stretch_factor <=
        rss_pkg::RST_DELAY_HIGH[rss_pkg::STRETCH_BIT];
    end else if (wr_high) begin
      wait_slot_9               <= reg_wdata[rss_pkg::SLOT9_BIT];
      power_down_stretch_factor <= reg_wdata[rss_pkg::STRETCH_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      buck_pair_a_strobe_assign <= rss_pkg::RST_ASSIGN_A;
      buck_pair_b_strobe_assign <= rss_pkg::RST_ASSIGN_B;
    end else begin
      if (wr_a) begin
        buck_pair_a_strobe_assign <= reg_wdata;
      end
      if (wr_b) begin
        buck_pair_b_strobe_assign <= reg_wdata;
      end
    end
  end

  // Reserved bits of the high delay register read back as zero
  wire logic [7:0] high_view = {power_down_stretch_factor, 6'h00,
                                wait_slot_9};

  logic [7:0] next_rdata;
  always_comb begin
    case (reg_addr)
      rss_pkg::OFS_DELAY_LOW:  next_rdata = delay_select_low;
      rss_pkg::OFS_DELAY_HIGH: next_rdata = high_view;
      rss_pkg::OFS_ASSIGN_A:   next_rdata = buck_pair_a_strobe_assign;
      rss_pkg::OFS_ASSIGN_B:   next_rdata = buck_pair_b_strobe_assign;
      default:                 next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd_en) begin
      reg_rdata <= next_rdata;
    end
  end

  // ****************************************************************
  // Rail field decode
  // ****************************************************************
  wire logic [3:0] buck_rail_1_strobe_field =
    buck_pair_a_strobe_assign[rss_pkg::FIELD_LO_LSB +: rss_pkg::FIELD_W];
  wire logic [3:0] buck_rail_2_strobe_field =
    buck_pair_a_strobe_assign[rss_pkg::FIELD_HI_LSB +: rss_pkg::FIELD_W];
  wire logic [3:0] pair_b_lo_field =
    buck_pair_b_strobe_assign[rss_pkg::FIELD_LO_LSB +: rss_pkg::FIELD_W];
  wire logic [3:0] pair_b_hi_field =
    buck_pair_b_strobe_assign[rss_pkg::FIELD_HI_LSB +: rss_pkg::FIELD_W];

  wire logic [3:0] rail_hit = {
    field_hits(pair_b_hi_field, strobe_num),
    field_hits(pair_b_lo_field, strobe_num),
    field_hits(buck_rail_2_strobe_field, strobe_num),
    field_hits(buck_rail_1_strobe_field, strobe_num)
  };

  // Wait slot n sits between strobe n and n+1; index is slot - 1
  wire logic [8:0] wait_sel = {wait_slot_9, delay_select_low};
  wire logic [3:0] slot_up  = strobe_num;
  wire logic [3:0] slot_dn  = strobe_num - 4'h1;
  wire logic [3:0] slot_idx = (seq_dir_down ? slot_dn : slot_up) - 4'h1;
  wire logic       slot_long = wait_sel[slot_idx];

  // Stretch only applies on the way down
  wire logic stretch_now = seq_dir_down && power_down_stretch_factor;

  // Strobes 1 and 2 only exist while the seal is intact
  wire logic [3:0] low_strobe = freshness_seal_flag ?
                                rss_pkg::STROBE_SEALED_FIRST :
                                rss_pkg::STROBE_FIRST;

  wire logic at_end = seq_dir_down ? (strobe_num <= low_strobe)
                                   : (strobe_num >= rss_pkg::STROBE_LAST);

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  rss_pkg::rss_state_t state;
  rss_pkg::rss_state_t next_state;

  wire logic start_up   = (state == rss_pkg::RSS_IDLE) && power_up_req;
  wire logic start_down = (state == rss_pkg::RSS_IDLE) && !power_up_req &&
                          power_down_req;
  wire logic in_strobe  = (state == rss_pkg::RSS_STROBE);

  assign tif.load     = in_strobe && !at_end;
  assign tif.cycles   = wait_len(slot_long, stretch_now);
  assign strobe_pulse = in_strobe;
  assign seq_busy     = (state != rss_pkg::RSS_IDLE);

  always_comb begin
    case (state)
      rss_pkg::RSS_IDLE: begin
        next_state = (start_up || start_down) ? rss_pkg::RSS_STROBE
                                              : rss_pkg::RSS_IDLE;
      end
      rss_pkg::RSS_STROBE: begin
        next_state = at_end ? rss_pkg::RSS_IDLE : rss_pkg::RSS_WAIT;
      end
      rss_pkg::RSS_WAIT: begin
        next_state = tif.done ? rss_pkg::RSS_STROBE : rss_pkg::RSS_WAIT;
      end
      default: begin
        next_state = rss_pkg::RSS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= rss_pkg::RSS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seq_dir_down <= 1'b0;
    end else if (start_up) begin
      seq_dir_down <= 1'b0;
    end else if (start_down) begin
      seq_dir_down <= 1'b1;
    end
  end

  // Strobe counter: up from the lowest live strobe, down from the last
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strobe_num <= 4'h0;
    end else if (start_up) begin
      strobe_num <= low_strobe;
    end else if (start_down) begin
      strobe_num <= rss_pkg::STROBE_LAST;
    end else if ((state == rss_pkg::RSS_WAIT) && tif.done) begin
      strobe_num <= seq_dir_down ? strobe_num - 4'h1
                                 : strobe_num + 4'h1;
    end
  end

  // Rails outside sequencer control keep their level throughout
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rail_en <= 4'h0;
    end else if (in_strobe) begin
      rail_en <= seq_dir_down ? (rail_en & ~rail_hit)
                              : (rail_en | rail_hit);
    end
  end

endmodule : rss_sequencer

// file: verification/rss_host_model.sv
`timescale 1ns/1ps
// ****************************************************************
// Host side of the register port
// ****************************************************************
module rss_host_model (
  input  wire logic       clk,       // Clock
  input  wire logic [7:0] reg_rdata, // Read data
  output logic      [7:0] reg_addr,  // Subaddress
  output logic            reg_wr_en, // Write strobe
  output logic      [7:0] reg_wdata, // Write data
  output logic            reg_rd_en  // Read strobe
);
  initial begin
    reg_addr  = 8'h00;
    reg_wr_en = 1'b0;
    reg_wdata = 8'h00;
    reg_rd_en = 1'b0;
  end
  // Idle lines flip so a stale value never looks like a request
  task automatic idle();
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr  = ~reg_addr;
    reg_wdata = ~reg_wdata;
  endtask : idle
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(posedge clk);
    #1;
    idle();
    // Let an edge pass so the next request never lands in this time step
    @(posedge clk);
    #1;
  endtask : write_reg
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    reg_addr  = a;
    reg_rd_en = 1'b1;
    @(posedge clk);
    #1;
    idle();
    @(posedge clk);
    #1;
    d = reg_rdata;
  endtask : read_reg
endmodule : rss_host_model

// file: verification/rss_sequencer_chk.sv
`timescale 1ns/1ps
// ****************************************************************
// Port checks of the sequencer
// ****************************************************************
module rss_sequencer_chk #(
  parameter int SHORT_CYCLES = 4,
  parameter int LONG_CYCLES  = 10,
  parameter int STRETCH      = 10
) (
  input wire logic       clk,                 // Clock
  input wire logic       arst_n,              // Reset
  input wire logic [7:0] reg_addr,            // Subaddress
  input wire logic       reg_rd_en,           // Read strobe
  input wire logic [7:0] reg_rdata,           // Read data
  input wire logic       freshness_seal_flag, // Seal
  input wire logic [3:0] rail_en,             // Enables
  input wire logic [3:0] strobe_num,          // Strobe
  input wire logic       strobe_pulse,        // Pulse
  input wire logic       seq_busy,            // Busy
  input wire logic       seq_dir_down         // Direction
);
  localparam int S1 = SHORT_CYCLES + 1;
  localparam int L1 = LONG_CYCLES + 1;
  localparam int SD = SHORT_CYCLES * STRETCH + 1;
  localparam int LD = LONG_CYCLES * STRETCH + 1;
  logic [11:0] gap;
  logic [3:0]  last_num;
  // Clocks from one strobe pulse to the next
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gap      <= 12'h000;
      last_num <= 4'h0;
    end else if (strobe_pulse) begin
      gap      <= 12'h001;
      last_num <= strobe_num;
    end else begin
      gap <= gap + 12'h001;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_pulse_single; strobe_pulse |=> !strobe_pulse; endproperty
  a_pulse_single: assert property (p_pulse_single) else $error("long pulse");
  property p_first_up; $rose(seq_busy) && !seq_dir_down |-> strobe_pulse
    && strobe_num == ($past(freshness_seal_flag) ? 4'h3 : 4'h1); endproperty
  a_first_up: assert property (p_first_up) else $error("bad first");
  property p_first_dn; $rose(seq_busy) && seq_dir_down |-> strobe_num == 4'hA;
  endproperty
  a_first_dn: assert property (p_first_dn) else $error("bad top");
  property p_up_step; strobe_pulse && !seq_dir_down && $past(seq_busy)
    |-> strobe_num == last_num + 4'h1; endproperty
  a_up_step: assert property (p_up_step) else $error("up order");
  property p_dn_step; strobe_pulse && seq_dir_down && $past(seq_busy)
    |-> strobe_num == last_num - 4'h1; endproperty
  a_dn_step: assert property (p_dn_step) else $error("down order");
  property p_up_gap; strobe_pulse && !seq_dir_down && $past(seq_busy)
    |-> gap == S1 || gap == L1; endproperty
  a_up_gap: assert property (p_up_gap) else $error("up wait");
  property p_dn_gap; strobe_pulse && seq_dir_down && $past(seq_busy)
    |-> gap inside {S1, L1, SD, LD}; endproperty
  a_dn_gap: assert property (p_dn_gap) else $error("down wait");
  property p_rail_on; (rail_en & ~$past(rail_en)) != 4'h0
    |-> $past(strobe_pulse) && !seq_dir_down; endproperty
  a_rail_on: assert property (p_rail_on) else $error("stray enable");
  property p_rail_off; (~rail_en & $past(rail_en)) != 4'h0
    |-> $past(strobe_pulse) && seq_dir_down; endproperty
  a_rail_off: assert property (p_rail_off) else $error("stray disable");
  property p_rsvd; $past(reg_rd_en) && $past(reg_addr) == 8'h21
    |-> reg_rdata[6:1] == 6'h00; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
endmodule : rss_sequencer_chk

// file: verification/rss_sequencer_bench.sv
`timescale 1ns/1ps
module rss_sequencer_bench;
  localparam int SC = 4;
  localparam int LC = 10;
  localparam int ST = 10;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [7:0]  reg_addr;
  logic        reg_wr_en;
  logic [7:0]  reg_wdata;
  logic        reg_rd_en;
  logic [7:0]  reg_rdata;
  logic        up_req = 1'b0;
  logic        dn_req = 1'b0;
  logic        seal = 1'b0;
  logic [3:0]  rail_en;
  logic [3:0]  strobe_num;
  logic        strobe_pulse;
  logic        seq_busy;
  logic        seq_dir_down;
  logic [8:0]  dly;
  logic        stretch;
  logic [15:0] fields;
  int          errors = 0;
  int          checks = 0;
  rss_sequencer #(.SHORT_CYCLES(SC), .LONG_CYCLES(LC), .STRETCH(ST))
  u_rss_sequencer (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en),
    .reg_rdata(reg_rdata), .power_up_req(up_req), .power_down_req(dn_req),
    .freshness_seal_flag(seal), .rail_en(rail_en), .strobe_num(strobe_num),
    .strobe_pulse(strobe_pulse), .seq_busy(seq_busy),
    .seq_dir_down(seq_dir_down));
  rss_host_model u_rss_host_model (.clk(clk), .reg_rdata(reg_rdata),
    .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata),
    .reg_rd_en(reg_rd_en));
  always #2 clk = ~clk;
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  task automatic rd_check(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    u_rss_host_model.read_reg(a, d);
    check("register", d, e);
  endtask : rd_check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_rss_host_model.write_reg(a, d);
  endtask : wr
  // Bench keeps its own copy of the settings to derive expectations
  task automatic cfg(input logic [7:0] lo, hi, a, b);
    wr(8'h20, lo);
    wr(8'h21, hi);
    wr(8'h22, a);
    wr(8'h23, b);
    dly = {hi[0], lo};
    stretch = hi[7];
    fields = {b, a};
  endtask : cfg
  task automatic run_seq(input logic down, input logic [3:0] first);
    logic [3:0] k;
    logic [3:0] rails;
    int base;
    int waited;
    k = down ? 4'hA : first;
    rails = rail_en;
    if (down) dn_req = 1'b1;
    else up_req = 1'b1;
    @(posedge clk);
    #1;
    up_req = 1'b0;
    dn_req = 1'b0;
    check("first strobe", {strobe_pulse, strobe_num}, {1'b1, k});
    check("direction", seq_dir_down, down);
    for (int n = 0; n < 10; n++) begin
      @(posedge clk);
      #1;
      for (int i = 0; i < 4; i++)
        if (fields[4*i+:4] == k) rails[i] = !down;
      check("rails", rail_en, rails);
      if (k == (down ? first : 4'hA)) break;
      base = dly[down ? k - 4'h2 : k - 4'h1] ? LC : SC;
      if (down && stretch) base = base * ST;
      waited = 1;
      while (strobe_pulse !== 1'b1 && waited < 1200) begin
        @(posedge clk);
        #1;
        waited++;
      end
      check("wait", waited, base + 1);
      k = down ? k - 4'h1 : k + 4'h1;
      check("strobe", strobe_num, k);
    end
    check("idle", seq_busy, 1'b0);
  endtask : run_seq
  task automatic t_reset_values();
    rd_check(8'h20, 8'h00);
    rd_check(8'h21, 8'h00);
    rd_check(8'h22, 8'h86);
    rd_check(8'h23, 8'h84);
    rd_check(8'h24, 8'h00);
    $display("t_reset_values done");
  endtask : t_reset_values
  task automatic t_reserved_bits();
    wr(8'h21, 8'hFF);
    rd_check(8'h21, 8'h81);
    wr(8'h20, 8'hA5);
    rd_check(8'h20, 8'hA5);
    $display("t_reserved_bits done");
  endtask : t_reserved_bits
  task automatic t_stretched_cycle();
    cfg(8'h55, 8'h81, 8'hA3, 8'h0B);
    run_seq(1'b0, 4'h1);
    run_seq(1'b1, 4'h1);
    $display("t_stretched_cycle done");
  endtask : t_stretched_cycle
  task automatic t_sealed_cycle();
    seal = 1'b1;
    cfg(8'hAA, 8'h00, 8'h2F, 8'h45);
    run_seq(1'b0, 4'h3);
    run_seq(1'b1, 4'h3);
    $display("t_sealed_cycle done");
  endtask : t_sealed_cycle
  initial begin
    #40000;
    errors++;
    tally_and_finish();
  end
  initial begin
    repeat (5) @(posedge clk);
    #1;
    arst_n = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    t_reset_values();
    t_reserved_bits();
    t_stretched_cycle();
    t_sealed_cycle();
    tally_and_finish();
  end
endmodule : rss_sequencer_bench
bind rss_sequencer rss_sequencer_chk #(.SHORT_CYCLES(SHORT_CYCLES),
  .LONG_CYCLES(LONG_CYCLES), .STRETCH(STRETCH))
u_rss_sequencer_chk (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
  .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata), .rail_en(rail_en),
  .freshness_seal_flag(freshness_seal_flag), .strobe_num(strobe_num),
  .strobe_pulse(strobe_pulse), .seq_busy(seq_busy),
  .seq_dir_down(seq_dir_down));
